// File: rtl/async_indirect_line_regs_consts.vh
// offsets, field positions and reset values of the indirect line window
`ifndef ASYNC_INDIRECT_LINE_REGS_CONSTS_VH
`define ASYNC_INDIRECT_LINE_REGS_CONSTS_VH

// bus location of the window, byte offset from base
`define IND_OFFSET      9'h0E4
`define ADDR_W          9

// index fields
`define IDX_LINE_MSB    2
`define IDX_LINE_LSB    0
`define IDX_GRP_MSB     4
`define IDX_GRP_LSB     3
`define GRP_TX          2'h0

// silo shape
`define SILO_DEPTH      32
`define SILO_PTR_W      5
`define SILO_CNT_W      6
`define SILO_CNT_RST    6'h00

// modem status bits inside the read word
`define MDM_USER_BIT    10
`define MDM_SCF_BIT     11
`define MDM_CTS_BIT     12
`define MDM_CD_BIT      13
`define MDM_RI_BIT      14
`define MDM_DSR_BIT     15
`define MDM_RST         6'h00
`define MDM_LINES       2

// change entry fields
`define ENT_CHG_BIT     11
`define ENT_LINE_MSB    10
`define ENT_LINE_LSB    8

`endif

// File: rtl/tx_char_silo.v
// one line's 32-entry transmit character silo, up to two pushes per cycle
`timescale 1ns/100ps
`include "async_indirect_line_regs_consts.vh"
module tx_char_silo (
  input  wire                   i_clock,
  input  wire                   i_rst_b,
  input  wire                   i_clear,
  input  wire                   i_push_lo,
  input  wire                   i_push_hi,
  input  wire [7:0]             i_char_lo,
  input  wire [7:0]             i_char_hi,
  input  wire                   i_pop,
  output wire                   o_valid,
  output wire [7:0]             o_char,
  output wire [`SILO_CNT_W-1:0] o_count
);

  reg [7:0]             mem [0:`SILO_DEPTH-1];
  reg [`SILO_PTR_W-1:0] wr_ptr_ff;
  reg [`SILO_PTR_W-1:0] rd_ptr_ff;
  reg [`SILO_CNT_W-1:0] count_ff;
  reg [`SILO_CNT_W-1:0] nxt_count;
  reg [`SILO_PTR_W-1:0] nxt_wr_ptr;
  wire                  room1;
  wire                  room2;
  wire                  do_lo;
  wire                  do_hi;
  wire                  do_pop;

  // room judged before the pop; costs one slot for a cycle, avoids a loop
  assign room1  = (count_ff < `SILO_DEPTH);
  assign room2  = (count_ff < (`SILO_DEPTH - 1));
  assign do_lo  = i_push_lo & room1;
  assign do_hi  = i_push_lo & i_push_hi & room2;
  assign do_pop = i_pop & (count_ff != `SILO_CNT_RST);
  assign o_valid = (count_ff != `SILO_CNT_RST);
  assign o_char  = mem[rd_ptr_ff];
  assign o_count = count_ff;

  // next count and write pointer
  always @* begin
    nxt_count  = count_ff + {5'h00, do_lo} + {5'h00, do_hi}
                 - {5'h00, do_pop};
    nxt_wr_ptr = wr_ptr_ff + {4'h0, do_lo} + {4'h0, do_hi};
  end

  // storage has no reset; contents are invalid until counted
  always @(posedge i_clock) begin
    if (do_lo) begin
      mem[wr_ptr_ff] <= i_char_lo;
    end
    if (do_hi) begin
      mem[wr_ptr_ff + 5'h01] <= i_char_hi;
    end
  end

  // pointers and count; init empties the silo
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr_ff <= 5'h00;
      rd_ptr_ff <= 5'h00;
      count_ff  <= `SILO_CNT_RST;
    end else if (i_clear) begin
      wr_ptr_ff <= 5'h00;
      rd_ptr_ff <= 5'h00;
      count_ff  <= `SILO_CNT_RST;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= rd_ptr_ff + {4'h0, do_pop};
      count_ff  <= nxt_count;
    end
  end

endmodule // tx_char_silo

// File: rtl/async_indirect_line_regs.v
// indirect group 0 window: per-line transmit silos, modem status for lines 0 and 1
`timescale 1ns/100ps
`include "async_indirect_line_regs_consts.vh"
module async_indirect_line_regs (
  input  wire               i_clock,
  input  wire               i_rst_b,
  input  wire               i_bus_init,
  // host register access
  input  wire [`ADDR_W-1:0] i_addr,
  input  wire               i_rd,
  input  wire               i_wr,
  input  wire               i_wr_byte,
  input  wire [15:0]        i_wdata,
  input  wire [4:0]         i_index,
  output wire               o_ack,
  output wire [15:0]        o_rdata,
  // transmitter drain side, one lane per line
  input  wire [7:0]         i_tx_pop,
  output wire [7:0]         o_tx_valid,
  output wire [63:0]        o_tx_char,
  // modem pins of lines 0 and 1
  input  wire [1:0]         i_user_rx,
  input  wire [1:0]         i_sec_cd,
  input  wire [1:0]         i_cts,
  input  wire [1:0]         i_cd,
  input  wire [1:0]         i_ring,
  input  wire [1:0]         i_dsr,
  input  wire [1:0]         i_cd_jumper_sec,
  // change reporting toward the receive silo
  input  wire [1:0]         i_chg_enable,
  input  wire               i_rx_silo_full,
  output wire               o_chg_valid,
  output wire [15:0]        o_chg_entry
);

  localparam NPIN = 14;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // true when the access lands on the window and the index picks group 0
  function grp_tx_hit;
    input [`ADDR_W-1:0] addr;
    input [4:0]         idx;
    begin
      grp_tx_hit = (addr == `IND_OFFSET) &&
                   (idx[`IDX_GRP_MSB:`IDX_GRP_LSB] == `GRP_TX);
    end
  endfunction

  // six modem signals packed as the upper status byte
  function [5:0] mdm_pack;
    input user;
    input scf;
    input cts;
    input cd;
    input ri;
    input dsr;
    begin
      mdm_pack = {dsr, ri, cd, cts, scf, user};
    end
  endfunction

  // true when the index's line field names line n; shared by write and read
  function line_is;
    input [2:0] sel;
    input [2:0] n;
    begin
      line_is = (sel == n);
    end
  endfunction

  // read word: modem byte on top, bits 9:8 empty, count in the low byte;
  // the count is six bits wide, so bits 7:6 of the low byte stay zero
  function [15:0] rd_word;
    input [5:0] mdm;
    input [5:0] cnt;
    begin
      rd_word = {mdm, 2'h0, 2'h0, cnt};
    end
  endfunction

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------

  wire       win_hit;
  wire       tx_hit;
  wire [2:0] line_sel;

  // index is sampled on the access itself and never moves on its own
  assign line_sel = i_index[`IDX_LINE_MSB:`IDX_LINE_LSB];
  assign win_hit  = (i_addr == `IND_OFFSET);
  assign tx_hit   = grp_tx_hit(i_addr, i_index);

  // one push request per line; only the addressed line sees it
  reg [7:0] push_lo;
  reg [7:0] push_hi;
  integer   k;

  always @* begin
    push_lo = 8'h00;
    push_hi = 8'h00;
    for (k = 0; k < 8; k = k + 1) begin
      if (i_wr && tx_hit && line_is(line_sel, k[2:0])) begin
        push_lo[k] = 1'b1;
        push_hi[k] = ~i_wr_byte;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit silos, one per line
  // ---------------------------------------------------------------

  wire [`SILO_CNT_W*8-1:0] silo_count;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_line
      // dma-mode writes are not guarded; host keeps to silo mode
      tx_char_silo u_silo (
        .i_clock   (i_clock),
        .i_rst_b   (i_rst_b),
        .i_clear   (i_bus_init),
        .i_push_lo (push_lo[g]),
        .i_push_hi (push_hi[g]),
        .i_char_lo (i_wdata[7:0]),
        .i_char_hi (i_wdata[15:8]),
        .i_pop     (i_tx_pop[g]),
        .o_valid   (o_tx_valid[g]),
        .o_char    (o_tx_char[g*8+7:g*8]),
        .o_count   (silo_count[g*`SILO_CNT_W+`SILO_CNT_W-1:
                               g*`SILO_CNT_W])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // modem pin synchronisers
  // ---------------------------------------------------------------

  wire [NPIN-1:0] pins_raw;
  reg  [NPIN-1:0] sync1_ff;
  reg  [NPIN-1:0] sync2_ff;
  reg  [NPIN-1:0] sync3_ff;
  reg  [NPIN-1:0] pins_ff;
  wire [NPIN-1:0] settled;

  assign pins_raw = {i_cd_jumper_sec, i_dsr, i_ring, i_cd,
                     i_cts, i_sec_cd, i_user_rx};

  // a pin counts only when stages two and three agree
  assign settled = ~(sync2_ff ^ sync3_ff);

  // three-stage capture; stage one feeds stage two only
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_ff <= 14'h0000;
      sync2_ff <= 14'h0000;
      sync3_ff <= 14'h0000;
      pins_ff  <= 14'h0000;
    end else begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pins_ff  <= (sync2_ff & settled) | (pins_ff & ~settled);
    end
  end

  // split the filtered pins back per signal
  wire [1:0] f_user = pins_ff[1:0];
  wire [1:0] f_scf  = pins_ff[3:2];
  wire [1:0] f_cts  = pins_ff[5:4];
  wire [1:0] f_cd   = pins_ff[7:6];
  wire [1:0] f_ri   = pins_ff[9:8];
  wire [1:0] f_dsr  = pins_ff[11:10];
  wire [1:0] f_jmp  = pins_ff[13:12];

  // live modem byte per line; the jumper swaps carrier for secondary
  wire [5:0] live0;
  wire [5:0] live1;

  assign live0 = mdm_pack(f_user[0],
                          f_scf[0],
                          f_cts[0],
                          f_jmp[0] ? f_scf[0] : f_cd[0],
                          f_ri[0],
                          f_dsr[0]);
  assign live1 = mdm_pack(f_user[1],
                          f_scf[1],
                          f_cts[1],
                          f_jmp[1] ? f_scf[1] : f_cd[1],
                          f_ri[1],
                          f_dsr[1]);

  // ---------------------------------------------------------------
  // modem status registers and change entries
  // ---------------------------------------------------------------

  reg  [5:0] mdm0_ff;
  reg  [5:0] mdm1_ff;
  reg  [5:0] nxt_mdm0;
  reg  [5:0] nxt_mdm1;
  reg        nxt_chg_valid;
  reg  [2:0] nxt_chg_line;
  reg        chg_valid_ff;
  reg  [2:0] chg_line_ff;
  wire       diff0;
  wire       diff1;
  // per line: a reported change still waiting for its entry
  reg  [1:0] pend_ff;
  reg  [1:0] nxt_pend;
  wire       want0;
  wire       want1;

  assign diff0 = (live0 != mdm0_ff);
  assign diff1 = (live1 != mdm1_ff);

  // a line wants an entry on a fresh difference or on a held change
  assign want0 = (diff0 | pend_ff[0]) & i_chg_enable[0];
  assign want1 = (diff1 | pend_ff[1]) & i_chg_enable[1];

  // update rule: follow freely while reporting is off; while on, move
  // only together with an entry, so a full silo simply holds the change
  always @* begin
    nxt_mdm0      = mdm0_ff;
    nxt_mdm1      = mdm1_ff;
    nxt_chg_valid = 1'b0;
    nxt_chg_line  = 3'h0;
    nxt_pend      = pend_ff & i_chg_enable;  // disabling drops a held change
    if (diff0 && !i_chg_enable[0]) begin
      nxt_mdm0 = live0;
    end
    if (diff1 && !i_chg_enable[1]) begin
      nxt_mdm1 = live1;
    end
    // a change seen while enabled is held until an entry carries it,
    // so a pin that flips back while the silo is full is not lost
    if (diff0 && i_chg_enable[0]) begin
      nxt_pend[0] = 1'b1;
    end
    if (diff1 && i_chg_enable[1]) begin
      nxt_pend[1] = 1'b1;
    end
    // one entry per cycle, line 0 first; the other waits a cycle
    if (!i_rx_silo_full) begin
      if (want0) begin
        nxt_mdm0      = live0;
        nxt_chg_valid = 1'b1;
        nxt_chg_line  = 3'h0;
        nxt_pend[0]   = 1'b0;
      end else if (want1) begin
        nxt_mdm1      = live1;
        nxt_chg_valid = 1'b1;
        nxt_chg_line  = 3'h1;
        nxt_pend[1]   = 1'b0;
      end
    end
  end

  // status and entry registers, cleared by reset and by init
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mdm0_ff      <= `MDM_RST;
      mdm1_ff      <= `MDM_RST;
      chg_valid_ff <= 1'b0;
      chg_line_ff  <= 3'h0;
      pend_ff      <= 2'h0;
    end else if (i_bus_init) begin
      mdm0_ff      <= `MDM_RST;
      mdm1_ff      <= `MDM_RST;
      chg_valid_ff <= 1'b0;
      chg_line_ff  <= 3'h0;
      pend_ff      <= 2'h0;
    end else begin
      mdm0_ff      <= nxt_mdm0;
      mdm1_ff      <= nxt_mdm1;
      chg_valid_ff <= nxt_chg_valid;
      chg_line_ff  <= nxt_chg_line;
      pend_ff      <= nxt_pend;
    end
  end

  // entry word: change flag, line number, zero character
  assign o_chg_valid = chg_valid_ff;
  assign o_chg_entry = {4'h0, 1'b1, chg_line_ff, 8'h00};

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------

  reg [5:0]  sel_cnt;
  reg [5:0]  sel_mdm;
  reg [15:0] nxt_rdata;
  reg [15:0] rdata_ff;
  reg        ack_ff;
  integer    j;

  // pick the addressed line's count and modem byte
  always @* begin
    sel_cnt = 6'h00;
    for (j = 0; j < 8; j = j + 1) begin
      if (line_is(line_sel, j[2:0])) begin
        sel_cnt = silo_count[j*`SILO_CNT_W +: `SILO_CNT_W];
      end
    end
    case (line_sel)
      3'h0:    sel_mdm = mdm0_ff;
      3'h1:    sel_mdm = mdm1_ff;
      default: sel_mdm = 6'h00;
    endcase
  end

  // other groups are outside this block and read as zero here;
  // bits 9:8 carry no modem signal and read zero
  always @* begin
    nxt_rdata = rdata_ff;
    if (i_rd && win_hit) begin
      if (tx_hit) begin
        nxt_rdata = rd_word(sel_mdm, sel_cnt);
      end else begin
        nxt_rdata = 16'h0000;
      end
    end
  end

  // one-cycle answer to any access on the window
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_ff <= 16'h0000;
      ack_ff   <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      ack_ff   <= (i_rd | i_wr) & win_hit;
    end
  end

  assign o_ack   = ack_ff;
  assign o_rdata = rdata_ff;

endmodule // async_indirect_line_regs

// File: testbench/line_regs_chk.sv
// port checker for the indirect line window
`timescale 1ns/100ps
`include "async_indirect_line_regs_consts.vh"
module line_regs_chk (
  input wire               i_clock,
  input wire               i_rst_b,
  input wire               i_bus_init,
  input wire [`ADDR_W-1:0] i_addr,
  input wire               i_rd,
  input wire               i_wr,
  input wire [4:0]         i_index,
  input wire [1:0]         i_chg_enable,
  input wire               i_rx_silo_full,
  input wire               o_ack,
  input wire [15:0]        o_rdata,
  input wire [7:0]         o_tx_valid,
  input wire               o_chg_valid,
  input wire [15:0]        o_chg_entry
);
  // window hits, decoded once
  wire hit    = (i_rd | i_wr) & (i_addr == `IND_OFFSET);
  wire rd_hit = i_rd & (i_addr == `IND_OFFSET);
  wire g0     = (i_index[4:3] == 2'h0);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  ack_on_hit_a: assert property (hit |=> o_ack)
    else $error("no ack after window access");
  ack_on_miss_a: assert property (!hit |=> !o_ack)
    else $error("ack without window access");
  grp_read_zero_a: assert property (rd_hit && !g0 |=> o_rdata == 16'h0000)
    else $error("other group read not zero");
  modem_hi_zero_a: assert property (
    rd_hit && g0 && i_index[2:1] != 2'h0 |=> o_rdata[15:8] == 8'h00)
    else $error("modem byte of line 2..7 not zero");
  count_pad_a: assert property (rd_hit |=> o_rdata[9:8] == 2'h0)
    else $error("bits 9:8 of read not zero");
  write_fills_a: assert property (i_wr && hit && g0 && !i_bus_init
    |=> o_tx_valid[$past(i_index[2:0])])
    else $error("silo empty after character write");
  init_clears_a: assert property (i_bus_init |=> o_tx_valid == 8'h00 ##0
    !o_chg_valid)
    else $error("bus init left state behind");
  rdata_hold_a: assert property (!rd_hit && !i_bus_init |=> $stable(o_rdata))
    else $error("read data moved without read");
  chg_full_a: assert property (i_rx_silo_full |=> !o_chg_valid)
    else $error("change entry while receive silo full");
  chg_enable_a: assert property (o_chg_valid |-> $past(i_chg_enable) != 2'h0)
    else $error("change entry without enable");
  chg_entry_a: assert property (o_chg_valid |-> o_chg_entry[15:12] == 4'h0 &&
    o_chg_entry[11] && o_chg_entry[10:9] == 2'h0 && o_chg_entry[7:0] == 8'h00)
    else $error("malformed change entry");
endmodule // line_regs_chk

bind async_indirect_line_regs line_regs_chk i_chk (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_bus_init(i_bus_init),
  .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_index(i_index),
  .i_chg_enable(i_chg_enable), .i_rx_silo_full(i_rx_silo_full),
  .o_ack(o_ack), .o_rdata(o_rdata), .o_tx_valid(o_tx_valid),
  .o_chg_valid(o_chg_valid), .o_chg_entry(o_chg_entry));

// File: testbench/host_bus_model.sv
// host processor model driving the register window
`timescale 1ns/100ps
`include "async_indirect_line_regs_consts.vh"
module host_bus_model (
  input  wire               i_clock,
  output reg  [`ADDR_W-1:0] o_addr,
  output reg                o_rd,
  output reg                o_wr,
  output reg                o_wr_byte,
  output reg  [15:0]        o_wdata,
  output reg  [4:0]         o_index
);
  initial begin
    o_addr = 9'h000;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wr_byte = 1'b0;
    o_wdata = 16'h0000;
    o_index = 5'h00;
  end

  // one-cycle request; lines stay in silo mode, so writes are legal
  task access(input rd, input byt, input [8:0] adr, input [4:0] idx,
              input [15:0] d);
    begin
      @(posedge i_clock);
      o_rd <= rd;
      o_wr <= !rd;
      o_wr_byte <= byt;
      o_addr <= adr;
      o_index <= idx;
      o_wdata <= d;
      @(posedge i_clock);
      o_rd <= 1'b0;
      o_wr <= 1'b0;
      o_wdata <= ~d; // released data is not left looking valid
      o_addr <= ~adr;
      @(posedge i_clock);
    end
  endtask
endmodule // host_bus_model

// File: testbench/tb_async_indirect_line_regs.sv
// self-checking bench for the indirect line window
`timescale 1ns/100ps
`include "async_indirect_line_regs_consts.vh"
module tb_async_indirect_line_regs;
  reg         i_clock = 1'b0;
  reg         i_rst_b = 1'b0;
  reg         i_bus_init = 1'b0;
  reg  [7:0]  i_tx_pop = 8'h00;
  reg  [11:0] mdm = 12'h000; // bit 2k+line feeds status bit 10+k
  reg  [1:0]  jmp = 2'h0;
  reg  [1:0]  i_chg_enable = 2'h0;
  reg         i_rx_silo_full = 1'b0;
  wire [8:0]  h_addr;
  wire        h_rd, h_wr, h_byte, o_ack, o_chg_valid;
  wire [15:0] h_wdata, o_rdata, o_chg_entry;
  wire [4:0]  h_index;
  wire [7:0]  o_tx_valid;
  wire [63:0] o_tx_char;
  integer     error_cnt = 0;
  integer     n_compared = 0;
  integer     seed = 43;
  reg  [16:0] rd_q[$];
  reg  [15:0] chg_q[$];
  reg  [7:0]  cq[$];
  reg  [16:0] note;

  always #2 i_clock = ~i_clock;

  host_bus_model i_host (.i_clock(i_clock), .o_addr(h_addr), .o_rd(h_rd),
    .o_wr(h_wr), .o_wr_byte(h_byte), .o_wdata(h_wdata), .o_index(h_index));

  async_indirect_line_regs i_dut (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_bus_init(i_bus_init), .i_addr(h_addr), .i_rd(h_rd), .i_wr(h_wr),
    .i_wr_byte(h_byte), .i_wdata(h_wdata), .i_index(h_index),
    .o_ack(o_ack), .o_rdata(o_rdata), .i_tx_pop(i_tx_pop),
    .o_tx_valid(o_tx_valid), .o_tx_char(o_tx_char),
    .i_user_rx(mdm[1:0]), .i_sec_cd(mdm[3:2]), .i_cts(mdm[5:4]),
    .i_cd(mdm[7:6]), .i_ring(mdm[9:8]), .i_dsr(mdm[11:10]),
    .i_cd_jumper_sec(jmp), .i_chg_enable(i_chg_enable),
    .i_rx_silo_full(i_rx_silo_full), .o_chg_valid(o_chg_valid),
    .o_chg_entry(o_chg_entry));

  task check(input [8*8-1:0] nm, input [15:0] e, input [15:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask

  task wr(input byt, input [4:0] idx, input [15:0] d);
    begin
      rd_q.push_back(17'h00000);
      i_host.access(1'b0, byt, `IND_OFFSET, idx, d);
    end
  endtask

  task rd(input [4:0] idx, input [15:0] e);
    begin
      rd_q.push_back({1'b1, e});
      i_host.access(1'b1, 1'b0, `IND_OFFSET, idx, 16'h0000);
    end
  endtask

  // head char is checked before each pop, in silo order
  task pop(input integer n);
    begin
      @(negedge i_clock);
      check("txchar", {8'h00, cq.pop_front()}, {8'h00, o_tx_char[8*n +: 8]});
      check("txvalid", 16'h0001, {15'h0000, o_tx_valid[n]});
      @(posedge i_clock);
      i_tx_pop[n] <= 1'b1;
      @(posedge i_clock);
      i_tx_pop[n] <= 1'b0;
    end
  endtask

  // watcher: every ack or change entry takes the oldest note
  always @(negedge i_clock) begin
    if (o_ack === 1'b1) begin
      if (rd_q.size() == 0) check("ack", 16'h0000, 16'h0001);
      else begin
        note = rd_q.pop_front();
        if (note[16]) check("rdata", note[15:0], o_rdata);
      end
    end
    if (o_chg_valid === 1'b1) begin
      if (chg_q.size() == 0) check("chg", 16'h0000, 16'h0001);
      else check("chgent", chg_q.pop_front(), o_chg_entry);
    end
  end

  task summarize;
    begin
      if (error_cnt == 0 && n_compared > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // a hang costs far more than the whole sequence needs
  initial begin
    #40000;
    error_cnt = error_cnt + 1;
    summarize;
  end

  initial begin : main
    integer k, l;
    reg [15:0] d;
    repeat (4) @(posedge i_clock);
    i_rst_b <= 1'b1;
    for (l = 0; l < 8; l = l + 1) rd(l, 16'h0000);
    // word then byte write, low char first
    wr(1'b0, 5'h03, 16'h4241);
    cq.push_back(8'h41);
    cq.push_back(8'h42);
    rd(5'h03, 16'h0002);
    pop(3);
    pop(3);
    wr(1'b1, 5'h03, 16'h7F55);
    cq.push_back(8'h55);
    rd(5'h03, 16'h0001);
    pop(3);
    rd(5'h03, 16'h0000);
    // fill line 5 to 31, word write with one slot, then write to full
    for (k = 0; k < 15; k = k + 1) begin
      d = $random(seed);
      wr(1'b0, 5'h05, d);
      cq.push_back(d[7:0]);
      cq.push_back(d[15:8]);
    end
    d = $random(seed);
    wr(1'b1, 5'h05, d);
    cq.push_back(d[7:0]);
    rd(5'h05, 16'h001F);
    d = $random(seed);
    wr(1'b0, 5'h05, d);
    cq.push_back(d[7:0]);
    rd(5'h05, 16'h0020);
    d = $random(seed);
    wr(1'b0, 5'h05, d);
    rd(5'h05, 16'h0020);
    for (k = 0; k < 32; k = k + 1) pop(5);
    rd(5'h05, 16'h0000);
    // other groups and other addresses
    wr(1'b0, 5'h0A, 16'h1234);
    for (k = 1; k < 4; k = k + 1) rd({k[1:0], 3'h2}, 16'h0000);
    i_host.access(1'b0, 1'b0, 9'h0E2, 5'h02, 16'h1111);
    rd(5'h02, 16'h0000);
    // each modem pin to its status bit, change reporting off
    for (l = 0; l < 2; l = l + 1) for (k = 0; k < 6; k = k + 1) begin
      mdm <= 12'h001 << (2 * k + l);
      repeat (6) @(posedge i_clock);
      rd(l, 16'h0400 << k);
    end
    mdm <= 12'h004;
    jmp <= 2'h1;
    repeat (6) @(posedge i_clock);
    rd(5'h00, 16'h2800);
    d = $random(seed);
    jmp <= d[13:12];
    mdm <= d[11:0];
    repeat (6) @(posedge i_clock);
    for (l = 2; l < 8; l = l + 1) rd(l[4:0], 16'h0000);
    rd(5'h00, {d[10], d[8], d[12] ? d[2] : d[6], d[4], d[2], d[0],
               10'h000});
    jmp <= 2'h0;
    mdm <= 12'h000;
    repeat (6) @(posedge i_clock);
    // a change held while the receive silo is full
    i_chg_enable <= 2'h1;
    i_rx_silo_full <= 1'b1;
    mdm <= 12'h400;
    repeat (8) @(posedge i_clock);
    rd(5'h00, 16'h0000);
    chg_q.push_back(16'h0800);
    i_rx_silo_full <= 1'b0;
    repeat (4) @(posedge i_clock);
    rd(5'h00, 16'h8000);
    chg_q.push_back(16'h0900);
    i_chg_enable <= 2'h2;
    mdm <= 12'hC00;
    repeat (8) @(posedge i_clock);
    rd(5'h01, 16'h8000);
    // bus init empties silos and modem bytes
    i_chg_enable <= 2'h0;
    mdm <= 12'h000;
    d = $random(seed);
    wr(1'b0, 5'h00, d);
    @(posedge i_clock);
    i_bus_init <= 1'b1;
    @(posedge i_clock);
    i_bus_init <= 1'b0;
    rd(5'h00, 16'h0000);
    repeat (4) @(posedge i_clock);
    check("pending", 16'h0000, rd_q.size() + chg_q.size());
    summarize;
  end
endmodule // tb_async_indirect_line_regs
